// ### verilog/pew_consts.vh
/*
 * Constants for the parallel byte-wide nonvolatile memory host controller.
 * Assumes a 100 MHz clock and a single memory device on the pin bus.
 */
`ifndef PEW_CONSTS_VH
`define PEW_CONSTS_VH

// =============================================================
// Array geometry
`define PEW_ADDR_W 13
`define PEW_DATA_W 8
`define PEW_TOP_BIT 7
`define PEW_ID_FIRST 13'h1fe0
`define PEW_ID_LAST 13'h1fff

// =============================================================
// Timing, in nanoseconds, microseconds or milliseconds, and the clock period
`define PEW_CLK_NS 10
`define PEW_SETUP_NS 50
`define PEW_PULSE_NS 100
`define PEW_HOLD_NS 50
`define PEW_ACC_NS 250
`define PEW_SETUP_CYC ((`PEW_SETUP_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_PULSE_CYC ((`PEW_PULSE_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_HOLD_CYC ((`PEW_HOLD_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_ACC_CYC ((`PEW_ACC_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_WC_US 1000
`define PEW_WC_CYC (`PEW_WC_US * 1000 / `PEW_CLK_NS)
`define PEW_CLR_MS 10
`define PEW_CLR_CYC (`PEW_CLR_MS * 1000000 / `PEW_CLK_NS)
`define PEW_PWR_MS 5
`define PEW_PWR_CYC (`PEW_PWR_MS * 1000000 / `PEW_CLK_NS)

// =============================================================
// Command codes
`define PEW_CMD_READ 2'h0
`define PEW_CMD_WRITE 2'h1
`define PEW_CMD_CLEAR 2'h2

`endif

// ### verilog/pew_timer.v
/*
 * Down counter used by the host controller for pin phases and timeouts.
 * Assumes the same clock and synchronous reset as the controller.
 */
`timescale 1ns/1ps

// =============================================================
// Loadable down counter with a done flag
module pew_timer (
	clk,
	rst_n,
	load,
	loadVal,
	done
);
	input wire clk;
	input wire rst_n;
	input wire load;
	input wire [26:0] loadVal;
	output wire done;

	reg [26:0] cnt_ff;

	// Load wins over counting so a phase always starts from its full length.
	always @(posedge clk) begin
		if (!rst_n) begin
			cnt_ff <= 27'h0;
		end else if (load) begin
			cnt_ff <= loadVal;
		end else if (cnt_ff != 27'h0) begin
			cnt_ff <= cnt_ff - 27'h1;
		end
	end

	assign done = (cnt_ff == 27'h0);
endmodule // pew_timer

// ### verilog/pew_host.v
/*
 * Host controller for an asynchronous 8K x 8 byte-wide nonvolatile memory.
 * Assumes the memory sits on the pins below, busy line included; id/erase high-voltage
 * switches are driven by board logic from the enables given here.
 */
`timescale 1ns/1ps
`include "pew_consts.vh"

// Overview of operation
// - Write starts by write strobe low pulse with select low, drive high.
// - Host may reuse its bus once address and data are captured.
// - Host waits for write completion before the next access; without polling it waits the write-cycle time only.
// - Select low, drive at 12 V, 10 ms strobe pulse clears all.
// - Line nine at 12 V maps 0x1fe0-0x1fff to 32 id bytes.
module pew_host (
	clk,
	rst_n,
	reqValid,
	reqCmd,
	reqAddr,
	reqData,
	reqId,
	usePoll,
	reqReady,
	rspValid,
	rspData,
	rspTimeout,
	memAddr,
	memDataOut,
	memDataOe,
	memDataIn,
	memCeN,
	memOeN,
	memWeN,
	memOeHv,
	idSelectHv,
	memBusyN
);
	parameter WC_CYC = `PEW_WC_CYC;
	parameter CLR_CYC = `PEW_CLR_CYC;
	parameter PWR_CYC = `PEW_PWR_CYC;

	input wire clk;
	input wire rst_n;
	input wire reqValid;
	input wire [1:0] reqCmd;
	input wire [`PEW_ADDR_W-1:0] reqAddr;
	input wire [`PEW_DATA_W-1:0] reqData;
	input wire reqId;
	input wire usePoll;
	output reg reqReady;
	output reg rspValid;
	output reg [`PEW_DATA_W-1:0] rspData;
	output reg rspTimeout;
	output reg [`PEW_ADDR_W-1:0] memAddr;
	output reg [`PEW_DATA_W-1:0] memDataOut;
	output reg memDataOe;
	input wire [`PEW_DATA_W-1:0] memDataIn;
	output reg memCeN;
	output reg memOeN;
	output reg memWeN;
	output reg memOeHv;
	output reg idSelectHv;
	input wire memBusyN;

	localparam S_PWR = 4'h0;
	localparam S_IDLE = 4'h1;
	localparam S_RD = 4'h2;
	localparam S_WSET = 4'h3;
	localparam S_WPUL = 4'h4;
	localparam S_WHLD = 4'h5;
	localparam S_WAIT = 4'h6;
	localparam S_POLL = 4'h7;
	localparam S_PEND = 4'h8;
	localparam S_CSET = 4'h9;
	localparam S_CPUL = 4'ha;
	localparam S_CHLD = 4'hb;

	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	reg [`PEW_DATA_W-1:0] dinMeta_ff;
	reg [`PEW_DATA_W-1:0] dinSync_ff;
	reg busyMeta_ff;
	reg busySync_ff;
	reg [`PEW_DATA_W-1:0] wrData_ff;
	reg [26:0] guard_ff;
	reg tmrLoad;
	reg [26:0] tmrVal;
	wire tmrDone;

	// Truncate a cycle count to the timer's width.
	function [26:0] cyc27;
		input integer n;
		begin
			cyc27 = n[26:0];
		end
	endfunction

	// =============================================================
	// Pin synchronisers
	// Both pins come from the asynchronous memory, so each passes two flops.
	always @(posedge clk) begin
		if (!rst_n) begin
			dinMeta_ff <= 8'h00;
			dinSync_ff <= 8'h00;
			busyMeta_ff <= 1'b1;
			busySync_ff <= 1'b1;
		end else begin
			dinMeta_ff <= memDataIn;
			dinSync_ff <= dinMeta_ff;
			busyMeta_ff <= memBusyN;
			busySync_ff <= busyMeta_ff;
		end
	end

	pew_timer u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.load(tmrLoad),
		.loadVal(tmrVal),
		.done(tmrDone)
	);

	// =============================================================
	// Sequencer
	// The next state and which phase length to load into the timer.
	always @* begin
		nxt_state = state_ff;
		tmrLoad = 1'b0;
		tmrVal = 27'h0;
		case (state_ff)
			S_PWR: begin
				if (tmrDone && guard_ff != 27'h0) begin
					nxt_state = S_IDLE;
				end
			end
			S_IDLE: begin
				if (reqValid && reqCmd == `PEW_CMD_WRITE) begin
					nxt_state = S_WSET;
					tmrLoad = 1'b1;
					tmrVal = cyc27(`PEW_SETUP_CYC);
				end else if (reqValid && reqCmd == `PEW_CMD_CLEAR) begin
					nxt_state = S_CSET;
					tmrLoad = 1'b1;
					tmrVal = cyc27(`PEW_SETUP_CYC);
				end else if (reqValid) begin
					nxt_state = S_RD;
					tmrLoad = 1'b1;
					tmrVal = cyc27(`PEW_ACC_CYC + 2);
				end
			end
			S_RD: begin
				if (tmrDone) begin
					nxt_state = S_IDLE;
				end
			end
			S_WSET: begin
				if (tmrDone) begin
					nxt_state = S_WPUL;
					tmrLoad = 1'b1;
					tmrVal = cyc27(`PEW_PULSE_CYC);
				end
			end
			S_WPUL: begin
				if (tmrDone) begin
					nxt_state = S_WHLD;
					tmrLoad = 1'b1;
					tmrVal = cyc27(`PEW_HOLD_CYC);
				end
			end
			S_WHLD: begin
				if (tmrDone) begin
					nxt_state = S_WAIT;
					tmrLoad = 1'b1;
					tmrVal = cyc27(WC_CYC);
				end
			end
			S_WAIT: begin
				// polling path when no busy line is fitted
				if (usePoll) begin
					nxt_state = S_POLL;
					tmrLoad = 1'b1;
					tmrVal = cyc27(`PEW_ACC_CYC + 2);
				end else if (tmrDone) begin
					nxt_state = S_PEND;
				end
			end
			S_POLL: begin
				if (tmrDone) begin
					nxt_state = S_WAIT;
				end
			end
			S_PEND: begin
				nxt_state = S_IDLE;
			end
			S_CSET: begin
				if (tmrDone) begin
					nxt_state = S_CPUL;
					tmrLoad = 1'b1;
					tmrVal = cyc27(CLR_CYC);
				end
			end
			S_CPUL: begin
				if (tmrDone) begin
					nxt_state = S_CHLD;
					tmrLoad = 1'b1;
					tmrVal = cyc27(`PEW_HOLD_CYC);
				end
			end
			S_CHLD: begin
				if (tmrDone) begin
					nxt_state = S_IDLE;
				end
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
		if (state_ff == S_PWR && guard_ff == 27'h0) begin
			tmrLoad = 1'b1;
			tmrVal = cyc27(PWR_CYC);
		end
	end

	// =============================================================
	// State, pins and answers
	// Every pin and answer is a flop so the memory sees glitch-free strobes.
	always @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= S_PWR;
			guard_ff <= 27'h0;
			wrData_ff <= 8'h00;
			reqReady <= 1'b0;
			rspValid <= 1'b0;
			rspData <= 8'h00;
			rspTimeout <= 1'b0;
			memAddr <= 13'h0000;
			memDataOut <= 8'h00;
			memDataOe <= 1'b0;
			memCeN <= 1'b1;
			memOeN <= 1'b1;
			memWeN <= 1'b1;
			memOeHv <= 1'b0;
			idSelectHv <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			guard_ff <= 27'h1;
			rspValid <= 1'b0;
			rspTimeout <= 1'b0;
			reqReady <= (nxt_state == S_IDLE);
			if (state_ff == S_IDLE && reqValid) begin
				// id bytes sit at the top thirty-two addresses.
				memAddr <= reqAddr;
				idSelectHv <= reqId && reqAddr >= `PEW_ID_FIRST;
				memDataOut <= reqData;
				wrData_ff <= reqData;
				reqReady <= 1'b0;
			end
			memCeN <= !(nxt_state == S_RD || nxt_state == S_POLL ||
				(nxt_state >= S_WSET && nxt_state <= S_WHLD) ||
				(nxt_state >= S_CSET && nxt_state <= S_CHLD));
			memOeN <= !(nxt_state == S_RD || nxt_state == S_POLL);
			// strobe low only in the pulse phases
			memWeN <= !(nxt_state == S_WPUL || nxt_state == S_CPUL);
			// high drive voltage around the clear pulse
			memOeHv <= (nxt_state >= S_CSET && nxt_state <= S_CHLD);
			// host drives data only while the device floats it
			memDataOe <= (nxt_state >= S_WSET && nxt_state <= S_WHLD);
			if (state_ff == S_RD && tmrDone) begin
				rspValid <= 1'b1;
				rspData <= dinSync_ff;
			end
			// complement on the top bit means still busy
			if (state_ff == S_POLL && tmrDone &&
				dinSync_ff[`PEW_TOP_BIT] == wrData_ff[`PEW_TOP_BIT]) begin
				state_ff <= S_PEND;
				memCeN <= 1'b1;
				memOeN <= 1'b1;
			end
			// answer once the write-cycle timer runs out; timeout if busy is still low then
			if (state_ff == S_WAIT && !usePoll && tmrDone) begin
				rspTimeout <= !busySync_ff;
			end
			if (state_ff == S_PEND) begin
				rspValid <= 1'b1;
				rspData <= wrData_ff;
			end
			if (state_ff == S_CHLD && tmrDone) begin
				rspValid <= 1'b1;
			end
		end
	end
endmodule // pew_host

// ### sim/pew_host_assertions.sv
/* Checker for the memory host controller pins.
   Assumes it is bound to pew_host and sees only its ports. */
`timescale 1ns/1ps
// ========
// Pin rules
module pew_host_checker (
	input wire clk,
	input wire rst_n,
	input wire reqValid,
	input wire reqReady,
	input wire rspValid,
	input wire memDataOe,
	input wire memCeN,
	input wire memOeN,
	input wire memWeN,
	input wire memOeHv,
	input wire idSelectHv,
	input wire [12:0] memAddr,
	input wire [7:0] memDataOut
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_start; $fell(memWeN) && !memOeHv; endsequence
	sequence s_pulse; !memWeN [*8]; endsequence
	property p_weWithCe; !memWeN |-> !memCeN; endproperty
	a_weWithCe: assert property (p_weWithCe) else $error("strobe without select");
	property p_oeHigh; !memWeN && !memOeHv |-> memOeN; endproperty
	a_oeHigh: assert property (p_oeHigh) else $error("write with drive low");
	property p_pulse; s_start |-> s_pulse; endproperty
	a_pulse: assert property (p_pulse) else $error("write pulse short");
	property p_held; !memWeN && !$past(memWeN) && !memOeHv
		|-> $stable(memAddr) && $stable(memDataOut) && memDataOe; endproperty
	a_held: assert property (p_held) else $error("bus moved in pulse");
	property p_noFight; !memOeN |-> !memDataOe; endproperty
	a_noFight: assert property (p_noFight) else $error("data contention");
	property p_single; reqValid && reqReady |=> !reqReady; endproperty
	a_single: assert property (p_single) else $error("ready after take");
	property p_idRange; idSelectHv && !memCeN |-> memAddr >= 13'h1fe0; endproperty
	a_idRange: assert property (p_idRange) else $error("id select off range");
	property p_clear; $fell(memWeN) && memOeHv |-> !memCeN ##1 s_pulse; endproperty
	a_clear: assert property (p_clear) else $error("clear pulse bad");
	property p_early; $rose(memWeN) && !memOeHv |-> !rspValid [*8]; endproperty
	a_early: assert property (p_early) else $error("done too soon");
endmodule // pew_host_checker

bind pew_host pew_host_checker pew_host_checker_inst (.clk, .rst_n, .reqValid, .reqReady,
	.rspValid, .memDataOe, .memCeN, .memOeN, .memWeN, .memOeHv, .idSelectHv, .memAddr,
	.memDataOut);

// ### sim/pew_mem_model.sv
/* Behavioural byte-wide nonvolatile memory.
   Assumes the bench resolves the shared data wire. */
`timescale 1ns/1ps
// ========
// Memory device
module pew_mem_model (
	input wire [12:0] addr,
	input wire [7:0] dIn,
	input wire ceN,
	input wire oeN,
	input wire weN,
	input wire oeHv,
	input wire idHv,
	output reg [7:0] dOut,
	output wire busyN
);
	parameter PWR_NS = 200;
	parameter CLR_NS = 400;
	int wtNs = 1500;
	bit hasBusy = 1'h1;
	reg busy = 1'h0;
	reg [7:0] arr [0:8191];
	reg [7:0] idArr [0:31];
	reg [7:0] wData, lastOut;
	reg [12:0] wAddr;
	reg wId;
	time fallT;
	wire strobeN = ceN | weN;
	initial for (int i = 0; i < 8192; i++) begin
		arr[i] = 8'hff;
		idArr[i % 32] = 8'hff;
	end
	// open drain, pulled up when idle.
	assign busyN = !(busy && hasBusy);
	// address taken when the strobe falls.
	always @(negedge strobeN) begin
		fallT = $time;
		wAddr = addr;
		wId = idHv && addr >= 13'h1fe0;
	end
	// data on rise, then a self-timed cycle.
	always @(posedge strobeN)
		if (oeHv && $time - fallT >= CLR_NS) begin
			for (int i = 0; i < 8192; i++) arr[i] = 8'hff;
		end else if (oeN && !oeHv && !busy && $time >= PWR_NS) begin
			wData = dIn;
			busy = 1'h1;
			#(wtNs);
			if (wId) idArr[wAddr[4:0]] = wData;
			else arr[wAddr] = wData;
			busy = 1'h0;
		end
	// read, poll or release. A released bus shows junk.
	always @* begin
		if (!ceN && !oeN && weN && !oeHv) begin
			if (busy) dOut = {(addr == wAddr) ? ~wData[7] : 1'($random), 7'($random)};
			else if (idHv && addr >= 13'h1fe0) dOut = idArr[addr[4:0]];
			else dOut = arr[addr];
			lastOut = dOut;
		end else dOut = ~lastOut;
	end
endmodule // pew_mem_model

// ### sim/testbench.sv
/* Self-checking bench for the memory host controller.
   Assumes the design, checker and memory model are compiled first. */
`timescale 1ns/1ps
module testbench;
	reg clk = 1'h0, rst_n = 1'h0, reqValid = 1'h0, reqId = 1'h0, usePoll = 1'h0;
	reg [1:0] reqCmd = 2'h0;
	reg [12:0] reqAddr = 13'h0;
	reg [7:0] reqData = 8'h0;
	wire reqReady, rspValid, rspTimeout, memDataOe, memCeN, memOeN, memWeN;
	wire memOeHv, idSelectHv, memBusyN;
	wire [12:0] memAddr;
	wire [7:0] memDataOut, mDout, rspData;
	int failCount = 0, compares = 0, cyc = 0, seed = 1843, i;
	int refMem [0:8191];
	int refId [0:31];
	logic [7:0] got, d;
	logic [12:0] a;
	logic tOut;
	// The data wire follows whichever side enables it.
	wire [7:0] memDataIn = memDataOe ? memDataOut : mDout;
	pew_host #(.WC_CYC(200), .CLR_CYC(50), .PWR_CYC(20)) pew_host_inst (.clk, .rst_n,
		.reqValid, .reqCmd, .reqAddr, .reqData, .reqId, .usePoll, .reqReady, .rspValid,
		.rspData, .rspTimeout, .memAddr, .memDataOut, .memDataOe, .memDataIn, .memCeN,
		.memOeN, .memWeN, .memOeHv, .idSelectHv, .memBusyN);
	// The device's own hold-off ends just before the host's, so a skipped one loses a write.
	pew_mem_model #(.PWR_NS(250)) pew_mem_model_inst (.addr(memAddr), .dIn(memDataIn), .ceN(memCeN),
		.oeN(memOeN), .weN(memWeN), .oeHv(memOeHv), .idHv(idSelectHv), .dOut(mDout),
		.busyN(memBusyN));
	initial forever #5 clk = ~clk;
	// A hang is cut short well past the longest expected run.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failCount++;
			end_sim;
		end
	end
	task end_sim;
		if (failCount == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task check(input [7:0] seen, input [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failCount++;
			$display("unexpected at %0t: got %h, want %h", $time, seen, exp);
		end
	endtask
	// One request, taken when ready, valid for one cycle, then wait for the answer pulse.
	task automatic req(input [1:0] c, input [12:0] ra, input [7:0] rd, input id, input p);
		@(negedge clk);
		while (reqReady !== 1'h1) @(negedge clk);
		reqCmd = c;
		reqAddr = ra;
		reqData = rd;
		reqId = id;
		usePoll = p;
		reqValid = 1'h1;
		@(negedge clk);
		reqValid = 1'h0;
		do begin
			@(posedge clk);
			#1;
		end while (rspValid !== 1'h1 && rspTimeout !== 1'h1);
		got = rspData;
		tOut = rspTimeout;
	endtask
	task automatic wr(input [12:0] wa, input [7:0] wd, input id, input p);
		req(2'h1, wa, wd, id, p);
		check(got, wd);
		check({7'h0, tOut}, 8'h0);
		if (id) refId[wa[4:0]] = wd;
		else refMem[wa] = wd;
	endtask
	task automatic rd(input [1:0] c, input [12:0] ra, input id);
		req(c, ra, 8'h0, id, 1'h0);
		check(got, 8'(id ? refId[ra[4:0]] : refMem[ra]));
	endtask
	initial begin
		for (i = 0; i < 8192; i++) refMem[i] = 255;
		for (i = 0; i < 32; i++) refId[i] = 255;
		repeat (5) @(negedge clk);
		rst_n = 1'h1;
		// Random bytes, alternating busy line and polling, each read straight back.
		for (i = 0; i < 8; i++) begin
			a = 13'($random(seed));
			d = 8'($random(seed));
			pew_mem_model_inst.hasBusy = i[0];
			wr(a, d, 1'h0, !i[0]);
			rd(i[1] ? 2'h3 : 2'h0, a, 1'h0);
		end
		pew_mem_model_inst.hasBusy = 1'h1;
		// Id bytes at both ends of the window, main array left alone.
		wr(13'h1fe0, 8'h5a, 1'h1, 1'h0);
		wr(13'h1fff, 8'ha5, 1'h1, 1'h1);
		rd(2'h0, 13'h1fe0, 1'h1);
		rd(2'h0, 13'h1fff, 1'h1);
		rd(2'h0, 13'h1fe0, 1'h0);
		// A slow device outlasts the write time and is flagged.
		pew_mem_model_inst.wtNs = 2500;
		req(2'h1, 13'h0010, 8'h3c, 1'h0, 1'h0);
		check({7'h0, tOut}, 8'h1);
		wait (pew_mem_model_inst.busy == 1'h0);
		pew_mem_model_inst.wtNs = 1500;
		refMem[16] = 8'h3c;
		rd(2'h0, 13'h0010, 1'h0);
		// Chip clear sets every main-array byte high; two of them are read back, id bytes are not read.
		req(2'h2, 13'h0, 8'h0, 1'h0, 1'h0);
		for (i = 0; i < 8192; i++) refMem[i] = 255;
		rd(2'h0, 13'h0010, 1'h0);
		rd(2'h0, a, 1'h0);
		end_sim;
	end
endmodule // testbench
